// ### rtl/sacc_pkg.sv
// Package for the successive-approximation conversion control block.
// Assumes an APB master on pclk and an abstract analog front end.
package sacc_pkg;
    // Register byte offsets
    localparam logic [11:0] SACC_OFF_SCR   = 12'h000;
    localparam logic [11:0] SACC_OFF_RHI   = 12'h004;
    localparam logic [11:0] SACC_OFF_RLO   = 12'h008;
    localparam logic [11:0] SACC_OFF_CLK   = 12'h00C;
    localparam logic [11:0] SACC_OFF_PORT  = 12'h010;
    localparam logic [11:0] SACC_OFF_DDR   = 12'h014;
    localparam logic [11:0] SACC_OFF_PIN   = 12'h018;
    // Status/control field positions
    localparam int SACC_SCR_CH_LSB   = 0;
    localparam int SACC_SCR_CONT_BIT = 5;
    localparam int SACC_SCR_IEN_BIT  = 6;
    localparam int SACC_SCR_DONE_BIT = 7;
    // Clock config field positions
    localparam int SACC_CLK_SRC_BIT  = 4;
    localparam int SACC_CLK_FMT_LSB  = 2;
    localparam int SACC_CLK_DIV_LSB  = 5;
    // Reset values
    localparam logic [4:0] SACC_CH_RST   = 5'h1F;
    localparam logic [7:0] SACC_CLK_RST  = 8'h00;
    localparam logic [7:0] SACC_PORT_RST = 8'h00;
    // Channel codes
    localparam logic [4:0] SACC_CH_REFH = 5'h1D;
    localparam logic [4:0] SACC_CH_REFL = 5'h1E;
    localparam logic [4:0] SACC_CH_OFF  = 5'h1F;
    // Converter cycles spent sampling before the bit trials
    localparam logic [4:0] SACC_SAMPLE_CYC = 5'h06;
    // Result format codes, in listed order
    localparam logic [1:0] SACC_FMT_LEFT  = 2'h0;
    localparam logic [1:0] SACC_FMT_RIGHT = 2'h1;
    localparam logic [1:0] SACC_FMT_SIGN  = 2'h2;
    localparam logic [1:0] SACC_FMT_TRUNC = 2'h3;
    typedef enum logic [1:0] {SACC_IDLE, SACC_SAMPLE, SACC_TRIAL, SACC_STORE} sacc_state_e;
endpackage

// ### rtl/sacc_top.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes APB on pclk and an analog mux/comparator that answers trials.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sacc_top
    import sacc_pkg::*;
#(
    parameter int        RES_BITS = 10,
    parameter int        NPINS    = 8,
    parameter logic [7:0] FMT_MAP = {SACC_FMT_TRUNC, SACC_FMT_SIGN, SACC_FMT_RIGHT, SACC_FMT_LEFT}
) (
    // Clock, reset, enable
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Analog front end
    output logic      [4:0]         mux_select,
    output logic                    conv_power_on,
    output logic                    sample_hold,
    output logic      [RES_BITS-1:0] trial_code,
    input  wire logic               comp_result,
    // Shared port pins
    input  wire logic [NPINS-1:0]   pin_in,
    output logic      [NPINS-1:0]   pin_out,
    output logic      [NPINS-1:0]   pin_oe,
    // Interrupt request
    output logic                    conv_irq
);
    // Datapath slices are written for this size only
    if (RES_BITS != 10 || NPINS != 8) begin : g_bad_cfg
        $error("sacc_top supports only 10-bit results and 8 pins");
    end

    // Registers
    logic [4:0]          chan_r;
    logic                cont_r;
    logic                ien_r;
    logic                done_r;
    logic [7:0]          clkcfg_r;
    logic [7:0]          port_r;
    logic [7:0]          ddr_r;
    logic [7:0]          rhi_r;
    logic [7:0]          rlo_r;
    logic                lock_r;
    logic                irq_r;
    sacc_state_e         state_r;
    logic [4:0]          cnt_r;
    logic [3:0]          bit_r;
    logic [RES_BITS-1:0] sar_r;
    logic [RES_BITS-1:0] trial_r;
    logic                sh_r;
    logic [7:0]          div_r;
    logic                cclk_r;
    logic                start_r;
    logic [7:0]          pin_s1_r;
    logic [7:0]          pin_s2_r;
    logic                cmp_s1_r;
    logic                cmp_s2_r;
    logic [31:0]         prdata_r;
    logic                pready_r;
    logic                pslverr_r;
    logic                pwr_r;
    logic [7:0]          pin_out_r;
    logic [7:0]          pin_oe_r;

    // Bus decode; writes land on the edge that samples pready high
    wire acc    = psel && penable && !pready_r;
    wire wr     = psel && penable && pready_r && pwrite;
    wire rd     = acc && !pwrite;
    wire a_scr  = paddr == SACC_OFF_SCR;
    wire a_rhi  = paddr == SACC_OFF_RHI;
    wire a_rlo  = paddr == SACC_OFF_RLO;
    wire a_clk  = paddr == SACC_OFF_CLK;
    wire a_port = paddr == SACC_OFF_PORT;
    wire a_ddr  = paddr == SACC_OFF_DDR;
    wire a_pin  = paddr == SACC_OFF_PIN;
    wire mapped = a_scr | a_rhi | a_rlo | a_clk | a_port | a_ddr | a_pin;
    wire scr_wr = wr && a_scr;
    wire rhi_rd = rd && a_rhi;
    wire rlo_rd = rd && a_rlo;
    wire dat_rd = rhi_rd || rlo_rd;

    // Channel decode
    // Five-bit channel code
    wire       ch_pin = chan_r[4:3] == 2'b00;
    wire [7:0] ch_mask = ch_pin ? (8'h01 << chan_r[2:0]) : 8'h00;
    wire       pwr_on = pwr_r;

    // Format selection, mapped through parameter
    // Two format bits
    wire [1:0] fmt_code = clkcfg_r[SACC_CLK_FMT_LSB +: 2];
    wire [1:0] fmt      = FMT_MAP[fmt_code*2 +: 2];
    wire       interlock = fmt != SACC_FMT_TRUNC;

    // Converter clock tick: divide by 2^div, source bit picks raw bus rate
    wire [2:0] div_sel = clkcfg_r[SACC_CLK_DIV_LSB +: 3];
    wire [7:0] div_max = (8'h01 << div_sel) - 8'h01;
    wire       tick    = clkcfg_r[SACC_CLK_SRC_BIT] ? 1'b1 : (div_r >= div_max);

    // Formatted result
    logic [7:0] hi_nxt;
    logic [7:0] lo_nxt;
    always_comb begin
        hi_nxt = 8'h00;
        lo_nxt = 8'h00;
        case (fmt)
            SACC_FMT_LEFT: begin
                hi_nxt = sar_r[9:2];
                lo_nxt = {sar_r[1:0], 6'h00};
            end
            SACC_FMT_RIGHT: begin
                hi_nxt = {6'h00, sar_r[9:8]};
                lo_nxt = sar_r[7:0];
            end
            SACC_FMT_SIGN: begin
                hi_nxt = {~sar_r[9], sar_r[8:2]};
                lo_nxt = {sar_r[1:0], 6'h00};
            end
            SACC_FMT_TRUNC: begin
                hi_nxt = 8'h00;
                lo_nxt = sar_r[9:2];
            end
            default: begin
                hi_nxt = 8'h00;
                lo_nxt = 8'h00;
            end
        endcase
    end

    wire store_ok = !(interlock && lock_r);
    wire at_store = state_r == SACC_STORE && tick;
    wire stored   = at_store && store_ok;

    // Read data
    wire [7:0] scr_rd = {done_r & ~ien_r, ien_r, cont_r, chan_r};
    wire [7:0] pin_rd = ((ddr_r & port_r) | (~ddr_r & pin_s2_r)) & ~ch_mask;
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (a_scr) rd_byte = scr_rd;
        if (a_rhi) rd_byte = rhi_r;
        if (a_rlo) rd_byte = rlo_r;
        if (a_clk) rd_byte = clkcfg_r;
        if (a_port) rd_byte = port_r;
        if (a_ddr) rd_byte = ddr_r;
        if (a_pin) rd_byte = pin_rd;
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            pready_r  <= acc;
            pslverr_r <= acc && !mapped;
            prdata_r  <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_r   <= SACC_CH_RST;
            cont_r   <= 1'b0;
            ien_r    <= 1'b0;
            clkcfg_r <= SACC_CLK_RST;
            port_r   <= SACC_PORT_RST;
            ddr_r    <= SACC_PORT_RST;
            pwr_r    <= SACC_CH_RST != SACC_CH_OFF;
        end else if (clk_en) begin
            if (scr_wr) begin
                chan_r <= pwdata[SACC_SCR_CH_LSB +: 5];
                cont_r <= pwdata[SACC_SCR_CONT_BIT];
                ien_r  <= pwdata[SACC_SCR_IEN_BIT];
                pwr_r  <= pwdata[SACC_SCR_CH_LSB +: 5] != SACC_CH_OFF;
            end
            if (wr && a_clk) clkcfg_r <= pwdata[7:0];
            if (wr && a_port) port_r <= pwdata[7:0];
            if (wr && a_ddr) ddr_r <= pwdata[7:0];
        end
    end

    // Pin and comparator synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            pin_out_r <= 8'h00;
            pin_oe_r  <= 8'h00;
        end else if (clk_en) begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            cmp_s1_r <= comp_result;
            cmp_s2_r <= cmp_s1_r;
            // Mask lags a channel change by one cycle
            pin_out_r <= port_r & ~ch_mask;
            pin_oe_r  <= ddr_r & ~ch_mask;
        end
    end

    // Converter clock divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 8'h00;
        end else if (clk_en) begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
        end
    end

    // Conversion sequencer
    // Control write restarts conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SACC_IDLE;
            start_r <= 1'b0;
            cnt_r   <= 5'h00;
            bit_r   <= 4'h0;
            sar_r   <= '0;
            trial_r <= '0;
            sh_r    <= 1'b0;
        end else if (clk_en) begin
            if (scr_wr) begin
                start_r <= 1'b1;
                state_r <= SACC_IDLE;
                sh_r    <= 1'b0;
            end else if (tick) begin
                case (state_r)
                    SACC_IDLE: begin
                        if (start_r && pwr_on) begin
                            start_r <= 1'b0;
                            state_r <= SACC_SAMPLE;
                            cnt_r   <= 5'h00;
                            sh_r    <= 1'b1;
                        end else if (!pwr_on) begin
                            start_r <= 1'b0;
                        end
                    end
                    // Sample then ten trials and store
                    SACC_SAMPLE: begin
                        if (cnt_r == SACC_SAMPLE_CYC - 5'h01) begin
                            state_r <= SACC_TRIAL;
                            sh_r    <= 1'b0;
                            bit_r   <= 4'(RES_BITS - 1);
                            sar_r   <= '0;
                            trial_r <= {1'b1, {(RES_BITS-1){1'b0}}};
                        end
                        cnt_r <= cnt_r + 5'h01;
                    end
                    SACC_TRIAL: begin
                        if (cmp_s2_r) begin
                            sar_r[bit_r] <= 1'b1;
                        end
                        if (bit_r == 4'h0) begin
                            state_r <= SACC_STORE;
                        end else begin
                            trial_r <= (sar_r | (cmp_s2_r ? trial_r : '0))
                                       | ((trial_r & ~sar_r) >> 1);
                            bit_r   <= bit_r - 4'h1;
                        end
                    end
                    SACC_STORE: begin
                        state_r <= cont_r && pwr_on ? SACC_SAMPLE : SACC_IDLE;
                        cnt_r   <= 5'h00;
                        sh_r    <= cont_r && pwr_on;
                    end
                    default: state_r <= SACC_IDLE;
                endcase
            end
        end
    end

    // Result, interlock, flag and interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rhi_r  <= 8'h00;
            rlo_r  <= 8'h00;
            lock_r <= 1'b0;
            done_r <= 1'b0;
            irq_r  <= 1'b0;
        end else if (clk_en) begin
            // High read locks, low read unlocks
            if (rhi_rd && interlock) lock_r <= 1'b1;
            if (rlo_rd || !interlock) lock_r <= 1'b0;
            if (stored) begin
                rhi_r <= hi_nxt;
                rlo_r <= lo_nxt;
            end
            // Flag holds until data read or irq enable, set wins
            if (stored && !ien_r) done_r <= 1'b1;
            else if (dat_rd || ien_r) done_r <= 1'b0;
            // Raise at end, clear on data read or control write
            if (stored && ien_r) irq_r <= 1'b1;
            else if (dat_rd || scr_wr) irq_r <= 1'b0;
        end
    end

    // Outputs
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign mux_select    = chan_r;
    assign conv_power_on = pwr_r;
    assign sample_hold   = sh_r;
    assign trial_code    = trial_r;
    assign conv_irq      = irq_r;
    assign pin_out       = pin_out_r;
    assign pin_oe        = pin_oe_r;
endmodule
`default_nettype wire

// ### tb/sacc_analog_model.sv
// Behavioural analog front end: channel mux, references, ideal comparator.
// Assumes the converter synchronises comp_result itself.
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model
    import sacc_pkg::*;
(
    // Clock
    input  wire logic       pclk,
    // Converter side
    input  wire logic [4:0] mux_select,
    input  wire logic       conv_power_on,
    input  wire logic [9:0] trial_code,
    output logic            comp_result,
    // Pin channel level as a full-scale code
    input  wire logic [9:0] pin_level
);
    logic [9:0] vin;
    logic       tog_r = 1'b0;
    assign vin = (mux_select == SACC_CH_REFH) ? 10'h3FF :
                 (mux_select == SACC_CH_REFL) ? 10'h000 : pin_level;
    // Unpowered comparator says nothing useful, so keep it moving
    always @(posedge pclk) tog_r <= ~tog_r;
    assign comp_result = conv_power_on ? (vin >= trial_code) : tog_r;
endmodule
`default_nettype wire

// ### tb/sacc_properties.sv
// Port-level checks for the conversion control block.
// Assumes clk_en is held high and attaches by bind.
`timescale 1ns/1ps
`default_nettype none
module sacc_properties
    import sacc_pkg::*;
#(
    parameter int NPINS = 8
) (
    // Clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // APB
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    // Converter and pins
    input wire logic [4:0]       mux_select,
    input wire logic             conv_power_on,
    input wire logic             sample_hold,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic             conv_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire req     = psel && penable;
    wire acc     = req && pready;
    wire scr     = paddr == SACC_OFF_SCR;
    wire dat     = paddr == SACC_OFF_RHI || paddr == SACC_OFF_RLO;
    wire pin_sel = mux_select[4:3] == 2'h0;
    wire off     = mux_select == SACC_CH_OFF;
    wire wr_scr  = acc && pwrite && scr;
    wire rd_scr  = acc && !pwrite && scr;
    wire rd_pin  = acc && !pwrite && paddr == SACC_OFF_PIN;
    wire go      = wr_scr && pwdata[4:0] != SACC_CH_OFF;
    // Whole access phase counts, the clear may land before pready
    wire clr     = req && (dat && !pwrite || scr && pwrite);

    a_mux_follow: assert property (wr_scr |=> mux_select == $past(pwdata[4:0]))
        else $error("channel not taken from write");
    a_pin_mask: assert property (pin_sel && $stable(mux_select) |-> !pin_oe[mux_select[2:0]])
        else $error("selected pin still driven");
    a_pin_zero: assert property (rd_pin && pin_sel |-> !prdata[mux_select[2:0]])
        else $error("selected pin reads nonzero");
    a_write_starts: assert property (go |-> ##[1:40] sample_hold)
        else $error("control write started nothing");
    a_power_off: assert property (off [*2] |-> !conv_power_on && !sample_hold)
        else $error("converter active while off");
    a_irq_hold: assert property (conv_irq && !clr |=> conv_irq)
        else $error("irq dropped without a clear");
    a_irq_clear: assert property (wr_scr |=> !conv_irq)
        else $error("irq kept after control write");
    a_done_zero: assert property (rd_scr && prdata[SACC_SCR_IEN_BIT] |-> !prdata[SACC_SCR_DONE_BIT])
        else $error("done flag set with irq enabled");

    c_irq: cover property ($rose(conv_irq));
    c_pin: cover property (rd_pin && pin_sel);
    c_off: cover property (off ##1 !off);
endmodule
bind sacc_top sacc_properties #(.NPINS(NPINS)) u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .mux_select, .conv_power_on, .sample_hold, .pin_oe, .conv_irq);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench: APB register sequences against the converter control.
// Assumes the analog model answers trials and one wait state per access.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sacc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_f;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  mux_select;
    logic        conv_power_on, sample_hold, comp_result, conv_irq;
    logic [9:0]  trial_code, pin_level;
    logic [7:0]  pin_in, pin_out, pin_oe, rd;
    int          n_errors, checks_done, i;

    sacc_top u_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mux_select, .conv_power_on, .sample_hold,
        .trial_code, .comp_result, .pin_in, .pin_out, .pin_oe, .conv_irq);
    sacc_analog_model u_model (.pclk, .mux_select, .conv_power_on, .trial_code,
        .comp_result, .pin_level);

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic fail(input string s);
        n_errors++;
        $display("[FAIL] %0t %s", $time, s);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) fail($sformatf("got %h exp %h", got, exp));
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("no pready");
        rd    = prdata[7:0];
        err_f = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, SACC_OFF_SCR, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < 100);
        if (n >= 100) fail("no done flag");
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (conv_irq !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) fail("no irq");
    endtask
    function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] c);
        case (f)
            2'h0: fmt_exp = {c, 6'h00};
            2'h1: fmt_exp = {6'h00, c};
            2'h2: fmt_exp = {~c[9], c[8:0], 6'h00};
            default: fmt_exp = {8'h00, c[9:2]};
        endcase
    endfunction
    // Divider 8 keeps the comparator settled through its synchroniser
    task automatic conv_chk(input logic [1:0] f, input logic [4:0] ch, input logic [9:0] c);
        logic [15:0] e;
        e = fmt_exp(f, c);
        apb(1'b1, SACC_OFF_CLK, {3'h3, 1'b0, f, 2'h0});
        apb(1'b1, SACC_OFF_SCR, {3'h0, ch});
        wait_done();
        if (f != 2'h3) rdchk(SACC_OFF_RHI, e[15:8]);
        rdchk(SACC_OFF_RLO, e[7:0]);
        rdchk(SACC_OFF_SCR, {3'h0, ch});
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #200000;
        fail("watchdog expired");
        end_sim();
    end
    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        pin_in    = 8'hFF;
        pin_level = 10'h2D6;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(SACC_OFF_SCR, 8'h1F);
        rdchk(SACC_OFF_CLK, 8'h00);
        rdchk(SACC_OFF_PORT, 8'h00);
        apb(1'b0, 12'h01C, 8'h00);
        chk({rd[6:0], err_f}, 8'h01);
        $display("reset test done");
        for (i = 0; i < 4; i++) conv_chk(2'(i), 5'h03, 10'h2D6);
        conv_chk(SACC_FMT_RIGHT, SACC_CH_REFH, 10'h3FF);
        conv_chk(SACC_FMT_RIGHT, SACC_CH_REFL, 10'h000);
        $display("format test done");
        pin_level <= 10'h101;
        apb(1'b1, SACC_OFF_CLK, 8'h60);
        apb(1'b1, SACC_OFF_SCR, 8'h03);
        wait_done();
        rdchk(SACC_OFF_RHI, 8'h40);
        pin_level <= 10'h3C2;
        apb(1'b1, SACC_OFF_SCR, 8'h03);
        repeat (200) @(posedge pclk);
        rdchk(SACC_OFF_RLO, 8'h40);
        rdchk(SACC_OFF_RHI, 8'h40);
        $display("interlock test done");
        apb(1'b1, SACC_OFF_CLK, 8'h6C);
        pin_level <= 10'h155;
        apb(1'b1, SACC_OFF_SCR, 8'h23);
        repeat (400) @(posedge pclk);
        rdchk(SACC_OFF_RLO, 8'h55);
        // High read after low would lock an interlocked format
        apb(1'b0, SACC_OFF_RHI, 8'h00);
        pin_level <= 10'h2A8;
        repeat (400) @(posedge pclk);
        rdchk(SACC_OFF_RLO, 8'hAA);
        apb(1'b1, SACC_OFF_SCR, 8'h03);
        repeat (200) @(posedge pclk);
        pin_level <= 10'h0FC;
        repeat (400) @(posedge pclk);
        rdchk(SACC_OFF_RLO, 8'hAA);
        $display("continuous test done");
        apb(1'b1, SACC_OFF_CLK, 8'h64);
        pin_level <= 10'h2D6;
        apb(1'b1, SACC_OFF_SCR, 8'h43);
        wait_irq();
        rdchk(SACC_OFF_SCR, 8'h43);
        rdchk(SACC_OFF_RHI, 8'h02);
        rdchk(SACC_OFF_RLO, 8'hD6);
        @(posedge pclk);
        chk({7'h00, conv_irq}, 8'h00);
        apb(1'b1, SACC_OFF_SCR, 8'h43);
        wait_irq();
        apb(1'b1, SACC_OFF_SCR, 8'h03);
        @(posedge pclk);
        chk({7'h00, conv_irq}, 8'h00);
        wait_done();
        apb(1'b0, SACC_OFF_RLO, 8'h00);
        rdchk(SACC_OFF_SCR, 8'h03);
        apb(1'b1, SACC_OFF_CLK, 8'h10);
        apb(1'b1, SACC_OFF_SCR, 8'h03);
        wait_done();
        $display("interrupt test done");
        apb(1'b1, SACC_OFF_PORT, 8'hFF);
        apb(1'b1, SACC_OFF_DDR, 8'hFF);
        repeat (2) @(posedge pclk);
        chk(pin_oe, 8'hF7);
        chk(pin_out, 8'hF7);
        rdchk(SACC_OFF_PIN, 8'hF7);
        apb(1'b1, SACC_OFF_SCR, {3'h0, SACC_CH_OFF});
        repeat (2) @(posedge pclk);
        chk(pin_oe, 8'hFF);
        chk({7'h00, conv_power_on}, 8'h00);
        repeat (60) @(posedge pclk);
        chk({7'h00, sample_hold}, 8'h00);
        $display("pin test done");
        end_sim();
    end
endmodule
`default_nettype wire
